// File: inc/wdog_pkg.sv
package wdog_pkg;
  localparam logic [7:0] CTRL_IDX = 8'h21;
  localparam logic [7:0] STAT_IDX = 8'h22;
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
  localparam int CTRL_IF = 7;
  localparam int CTRL_IE = 6;
  localparam int CTRL_P3 = 5;
  localparam int CTRL_CE = 4;
  localparam int CTRL_EN = 3;
  localparam int STAT_WD = 3;
  localparam int STAT_BO = 2;
  localparam int STAT_EX = 1;
  localparam int STAT_PO = 0;
  localparam logic [3:0] STAT_RST = 4'h1;
  localparam logic [3:0] PSEL_RST = 4'h0;
  localparam logic [3:0] PSEL_MAX = 4'h9;
  localparam int OSC_HZ = 128000;
  localparam int BASE_OSC_CYC = 2048;
  localparam int WIN_CYC = 4;
  localparam logic [2:0] WIN_LOAD = 3'(WIN_CYC);
  localparam int N_PIN = 4;
  localparam int PIN_OSC = 0;
  localparam int PIN_BOR = 1;
  localparam int PIN_EXT = 2;
  localparam int PIN_FUSE = 3;
  typedef enum logic [1:0] {
    WIN_SHUT = 2'b00,
    WIN_OPEN = 2'b01
  } win_state_e;
endpackage : wdog_pkg

// File: rtl/wdog_top.sv
`timescale 1ns/100ps
module wdog_top import wdog_pkg::*; #(
  parameter int BASE_CYC = BASE_OSC_CYC  // oscillator cycles for code 0
) (
  input wire logic pclk,                 // system clock, 40 MHz
  input wire logic presetn,              // power-on reset, async, active low
  input wire logic psel,                 // apb select
  input wire logic penable,              // apb access phase
  input wire logic pwrite,               // apb direction
  input wire logic [11:0] paddr,         // apb byte address
  input wire logic [31:0] pwdata,        // apb write data
  output logic [31:0] prdata,            // apb read data
  output logic pready,                   // apb ready
  output logic pslverr,                  // apb error on unmapped address
  input wire logic wdog_osc,             // 128 kHz watchdog oscillator pin
  input wire logic safety_level_fuse,    // 1 = programmed, level 2
  input wire logic brownout_evt,         // brown-out reset level, async
  input wire logic pin_reset_evt,        // external reset level, async
  input wire logic chip_reset,           // chip reset, same clock
  input wire logic wdog_restart_instr,   // restart instruction pulse
  input wire logic irq_vector_ack,       // timeout vector executing
  input wire logic global_irq_en,        // cpu_status_word interrupt bit
  output logic timeout_irq_req,          // interrupt request level
  output logic wdog_reset_pulse,         // one-cycle watchdog reset
  output logic wdog_running              // counter running
);

  function automatic logic [20:0] limit_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > PSEL_MAX) ? PSEL_MAX : code;
    limit_of = 21'(BASE_CYC) << c;
  endfunction : limit_of

  // pin sampler: three flops, a change counts when the last two agree
  logic [N_PIN-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [N_PIN-1:0] nxt_lvl;
  logic [N_PIN-1:0] pin_rise;

  always_comb begin
    for (int i = 0; i < N_PIN; i++) begin
      nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
      pin_rise[i] = nxt_lvl[i] & ~lvl_ff[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= {safety_level_fuse, pin_reset_evt, brownout_evt, wdog_osc};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  // fuse captured once after release; level 2 is assumed until then
  // the sampler holds reset zeros for three edges, so capture waits until it is filled
  logic fuse_ff, fuse_done_ff, nxt_fuse, nxt_fuse_done;
  logic [1:0] fill_ff, nxt_fill;
  logic level2;

  always_comb begin
    nxt_fuse = fuse_ff;
    nxt_fuse_done = fuse_done_ff;
    nxt_fill = fill_ff;
    if (fill_ff != 2'h3) begin
      nxt_fill = fill_ff + 2'h1;
    end
    if (!fuse_done_ff && fill_ff == 2'h3 && s2_ff[PIN_FUSE] == s3_ff[PIN_FUSE]) begin
      nxt_fuse = s3_ff[PIN_FUSE];
      nxt_fuse_done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_ff <= 1'b1;
      fuse_done_ff <= 1'b0;
      fill_ff <= 2'h0;
    end else begin
      fuse_ff <= nxt_fuse;
      fuse_done_ff <= nxt_fuse_done;
      fill_ff <= nxt_fill;
    end
  end

  assign level2 = fuse_ff;

  // apb decode
  logic wr_acc, rd_setup, hit_ctrl, hit_stat;
  logic [7:0] wbyte;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (paddr == CTRL_ADDR) begin
      hit_ctrl = 1'b1;
    end else if (paddr == STAT_ADDR) begin
      hit_stat = 1'b1;
    end
  end

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_ctrl & ~hit_stat;

  logic wr_ctrl, wr_stat;
  assign wr_ctrl = wr_acc & hit_ctrl;
  assign wr_stat = wr_acc & hit_stat;

  // control register state
  logic timeout_irq_flag_ff, timeout_irq_enable_ff, wde_ff;
  logic [3:0] wdp_ff;
  logic nxt_timeout_irq_flag, nxt_timeout_irq_enable, nxt_wde;
  logic [3:0] nxt_wdp;
  win_state_e win_ff, nxt_win;
  logic [2:0] ce_cnt_ff, nxt_ce_cnt;
  logic ce_ff;
  logic [3:0] stat_ff, nxt_stat;
  logic wde_eff, arm_wr, timeout;
  logic [3:0] wr_psel;

  assign ce_ff = (win_ff == WIN_OPEN);
  // level 2 and a pending watchdog cause both hold enable high
  assign wde_eff = wde_ff | level2 | stat_ff[STAT_WD];
  assign arm_wr = wr_ctrl & wbyte[CTRL_CE] & wbyte[CTRL_EN];
  assign wr_psel = {wbyte[CTRL_P3], wbyte[2:0]};

  always_comb begin
    nxt_win = win_ff;
    nxt_ce_cnt = ce_cnt_ff;
    case (win_ff)
      WIN_SHUT: begin
        if (arm_wr) begin
          nxt_win = WIN_OPEN;
          nxt_ce_cnt = WIN_LOAD;
        end
      end
      WIN_OPEN: begin
        if (arm_wr) begin
          nxt_ce_cnt = WIN_LOAD;
        end else if (wr_ctrl || ce_cnt_ff == 3'h1) begin
          nxt_win = WIN_SHUT;
          nxt_ce_cnt = 3'h0;
        end else begin
          nxt_ce_cnt = ce_cnt_ff - 3'h1;
        end
      end
      default: begin
        nxt_win = WIN_SHUT;
        nxt_ce_cnt = 3'h0;
      end
    endcase
  end

  always_comb begin
    nxt_timeout_irq_flag = timeout_irq_flag_ff;
    nxt_timeout_irq_enable = timeout_irq_enable_ff;
    nxt_wde = wde_ff;
    nxt_wdp = wdp_ff;
    if (chip_reset) begin
      nxt_timeout_irq_enable = 1'b0;
      nxt_wde = 1'b0;
      nxt_wdp = PSEL_RST;
    end else if (wr_ctrl) begin
      nxt_timeout_irq_enable = wbyte[CTRL_IE];
      if (ce_ff && !wbyte[CTRL_CE]) begin
        nxt_wdp = wr_psel;
        nxt_wde = wbyte[CTRL_EN];
      end else if (wbyte[CTRL_EN]) begin
        nxt_wde = 1'b1;
      end
      // a late or out-of-order write keeps prescale and can only set enable, never clear it
    end
    if ((wr_ctrl && wbyte[CTRL_IF]) || irq_vector_ack) begin
      nxt_timeout_irq_flag = 1'b0;
    end
    if (timeout && timeout_irq_enable_ff) begin
      nxt_timeout_irq_flag = 1'b1;
      if (wde_eff) begin
        nxt_timeout_irq_enable = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_irq_flag_ff <= 1'b0;
      timeout_irq_enable_ff <= 1'b0;
      wde_ff <= 1'b0;
      wdp_ff <= PSEL_RST;
      win_ff <= WIN_SHUT;
      ce_cnt_ff <= 3'h0;
    end else begin
      timeout_irq_flag_ff <= nxt_timeout_irq_flag;
      timeout_irq_enable_ff <= nxt_timeout_irq_enable;
      wde_ff <= nxt_wde;
      wdp_ff <= nxt_wdp;
      win_ff <= nxt_win;
      ce_cnt_ff <= nxt_ce_cnt;
    end
  end

  // counter on synchronised oscillator edges
  logic [20:0] cnt_ff, nxt_cnt;
  logic rst_pulse_ff, nxt_rst_pulse;
  logic osc_tick;

  assign osc_tick = pin_rise[PIN_OSC];
  assign wdog_running = wde_eff | timeout_irq_enable_ff;
  assign timeout = wdog_running & osc_tick & (cnt_ff >= limit_of(wdp_ff) - 21'h1);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (!wdog_running || chip_reset || wdog_restart_instr || timeout) begin
      nxt_cnt = 21'h0;
    end else if (osc_tick) begin
      nxt_cnt = cnt_ff + 21'h1;
    end
    nxt_rst_pulse = timeout & ~timeout_irq_enable_ff & wde_eff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 21'h0;
      rst_pulse_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      rst_pulse_ff <= nxt_rst_pulse;
    end
  end

  assign wdog_reset_pulse = rst_pulse_ff;
  assign timeout_irq_req = timeout_irq_flag_ff & timeout_irq_enable_ff & global_irq_en;

  // reset causes: zero write clears, an arriving cause wins
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = stat_ff & wbyte[3:0];
    end
    if (rst_pulse_ff) begin
      nxt_stat[STAT_WD] = 1'b1;
    end
    if (pin_rise[PIN_BOR]) begin
      nxt_stat[STAT_BO] = 1'b1;
    end
    if (pin_rise[PIN_EXT]) begin
      nxt_stat[STAT_EX] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= STAT_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // read data latched in the setup phase, shown through the access phase
  logic [31:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_setup) begin
      nxt_rdata = 32'h0;
      if (hit_ctrl) begin
        nxt_rdata[7:0] = {timeout_irq_flag_ff, timeout_irq_enable_ff, wdp_ff[3], ce_ff, wde_eff, wdp_ff[2:0]};
      end else if (hit_stat) begin
        nxt_rdata[7:0] = {4'h0, stat_ff};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata = rdata_ff;

  rsv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && hit_stat |-> prdata[7:4] == 4'h0)
    else $error("reserved status bits not zero");

  lvl2_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    level2 |-> wde_eff && wdog_running)
    else $error("level 2 watchdog not running");

  cause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    stat_ff[STAT_WD] |-> wde_eff)
    else $error("enable clear while watchdog cause set");

  win_close_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce_ff && !arm_wr)[*4] |=> !ce_ff)
    else $error("change window not closed after four cycles");

  locked_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && !ce_ff && !chip_reset |=> wdp_ff == $past(wdp_ff))
    else $error("prescale changed outside window");

  pulse_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_reset_pulse |=> !wdog_reset_pulse && stat_ff[STAT_WD])
    else $error("watchdog reset pulse longer than one cycle");

  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    timeout_irq_req |-> global_irq_en && timeout_irq_enable_ff && timeout_irq_flag_ff)
    else $error("interrupt request without enables");

  ie_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    timeout && timeout_irq_enable_ff && wde_eff && !wr_ctrl |=> !timeout_irq_enable_ff && timeout_irq_flag_ff)
    else $error("interrupt enable kept after timeout");

  stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wdog_running |=> cnt_ff == 21'h0 && !wdog_reset_pulse)
    else $error("stopped watchdog counts");

  timeout_irq_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    timeout && timeout_irq_enable_ff |=> timeout_irq_flag_ff)
    else $error("timeout flag not set in interrupt mode");

  win_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    arm_wr |=> ce_ff)
    else $error("change window not opened");

  bo_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[PIN_BOR] |=> stat_ff[STAT_BO])
    else $error("brown-out cause not set");

  ext_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise[PIN_EXT] |=> stat_ff[STAT_EX])
    else $error("pin reset cause not set");

  po_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    stat_ff[STAT_PO] && !wr_stat |=> stat_ff[STAT_PO])
    else $error("power-on cause lost without a write");

  ack_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_vector_ack && !(timeout && timeout_irq_enable_ff) |=> !timeout_irq_flag_ff)
    else $error("timeout flag kept after vector");

  restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_restart_instr || chip_reset |=> cnt_ff == 21'h0)
    else $error("count not restarted");

  cnt_lim_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_ff < (21'(BASE_CYC) << PSEL_MAX))
    else $error("count beyond the longest legal period");

  fuse_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    fuse_done_ff |=> fuse_done_ff && $stable(fuse_ff))
    else $error("safety level changed after capture");

  timeout_rst_c: cover property (@(posedge pclk) disable iff (!presetn)
    wdog_reset_pulse);
  timeout_irq_c: cover property (@(posedge pclk) disable iff (!presetn)
    timeout_irq_req);
  disable_seq_c: cover property (@(posedge pclk) disable iff (!presetn)
    arm_wr ##[1:4] (wr_ctrl && !wbyte[CTRL_EN]) ##1 !wdog_running);
  cause_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(stat_ff[STAT_PO]));
  fuse_lvl2_c: cover property (@(posedge pclk) disable iff (!presetn)
    fuse_done_ff && level2);

endmodule : wdog_top

// File: verification/tb.sv
`timescale 1ns/100ps
module tb import wdog_pkg::*;;
  localparam int BASE = 4;
  localparam int LIMIT = 40000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic wdog_osc, safety_level_fuse, brownout_evt, pin_reset_evt, chip_reset;
  logic wdog_restart_instr, irq_vector_ack, global_irq_en;
  logic timeout_irq_req, wdog_reset_pulse, wdog_running;
  int miscompares, checks, cycles, pulses, seen;

  wdog_top #(.BASE_CYC(BASE)) wdog_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdog_osc(wdog_osc),
    .safety_level_fuse(safety_level_fuse), .brownout_evt(brownout_evt),
    .pin_reset_evt(pin_reset_evt), .chip_reset(chip_reset),
    .wdog_restart_instr(wdog_restart_instr), .irq_vector_ack(irq_vector_ack),
    .global_irq_en(global_irq_en), .timeout_irq_req(timeout_irq_req),
    .wdog_reset_pulse(wdog_reset_pulse), .wdog_running(wdog_running));

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rdc

  task automatic strobe(input int which);
    case (which)
      0: wdog_restart_instr <= 1'b1;
      1: chip_reset <= 1'b1;
      default: irq_vector_ack <= 1'b1;
    endcase
    @(posedge pclk);
    wdog_restart_instr <= 1'b0;
    chip_reset <= 1'b0;
    irq_vector_ack <= 1'b0;
    @(posedge pclk);
  endtask : strobe

  // bounded by three code-0 timeouts plus synchroniser slack
  task automatic wait_evt(input logic irq_mode);
    int n;
    n = 0;
    while ((irq_mode ? timeout_irq_req : wdog_reset_pulse) !== 1'b1 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n < 4000}, 32'h1);
  endtask : wait_evt

  task automatic por(input logic fuse);
    safety_level_fuse <= fuse;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : por

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // slow oscillator, deliberately off the pclk grid
  initial begin
    wdog_osc = 1'b0;
    forever #3906.3 wdog_osc = ~wdog_osc;
  end

  always @(posedge pclk) begin
    cycles++;
    if (wdog_reset_pulse === 1'b1)
      pulses++;
    if (cycles == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {brownout_evt, pin_reset_evt, chip_reset, wdog_restart_instr, irq_vector_ack} = '0;
    global_irq_en = 1'b1;
    presetn = 1'b0;
    safety_level_fuse = 1'b0;
    por(1'b0);
    rdc(STAT_ADDR, 8'h01);
    rdc(CTRL_ADDR, 8'h00);
    chk(wdog_running, 1'b0);
    brownout_evt <= 1'b1;
    pin_reset_evt <= 1'b1;
    repeat (6) @(posedge pclk);
    brownout_evt <= 1'b0;
    pin_reset_evt <= 1'b0;
    repeat (6) @(posedge pclk);
    xfer(1'b1, STAT_ADDR, 8'hfe);
    rdc(STAT_ADDR, 8'h06);
    xfer(1'b1, STAT_ADDR, 8'h00);
    rdc(STAT_ADDR, 8'h00);
    xfer(1'b1, CTRL_ADDR, 8'h08);
    rdc(CTRL_ADDR, 8'h08);
    chk(wdog_running, 1'b1);
    xfer(1'b1, CTRL_ADDR, 8'h01);
    rdc(CTRL_ADDR, 8'h08);
    xfer(1'b1, CTRL_ADDR, 8'h18);
    rdc(CTRL_ADDR, 8'h18);
    repeat (4) @(posedge pclk);
    rdc(CTRL_ADDR, 8'h08);
    xfer(1'b1, CTRL_ADDR, 8'h00);
    rdc(CTRL_ADDR, 8'h08);
    xfer(1'b1, CTRL_ADDR, 8'h18);
    xfer(1'b1, CTRL_ADDR, 8'h01);
    rdc(CTRL_ADDR, 8'h01);
    chk(wdog_running, 1'b0);
    // restarts spaced well inside the code-1 period must hold off any reset
    xfer(1'b1, CTRL_ADDR, 8'h08);
    seen = pulses;
    repeat (5) begin
      repeat (600) @(posedge pclk);
      strobe(0);
    end
    chk(pulses - seen, 0);
    strobe(1);
    rdc(CTRL_ADDR, 8'h00);
    xfer(1'b1, CTRL_ADDR, 8'h08);
    wait_evt(1'b0);
    @(posedge pclk);
    chk(wdog_reset_pulse, 1'b0);
    rdc(STAT_ADDR, 8'h08);
    xfer(1'b1, CTRL_ADDR, 8'h18);
    xfer(1'b1, CTRL_ADDR, 8'h00);
    rdc(CTRL_ADDR, 8'h08);
    xfer(1'b1, STAT_ADDR, 8'h00);
    xfer(1'b1, CTRL_ADDR, 8'h18);
    xfer(1'b1, CTRL_ADDR, 8'h00);
    rdc(CTRL_ADDR, 8'h00);
    xfer(1'b1, CTRL_ADDR, 8'h40);
    seen = pulses;
    wait_evt(1'b1);
    rdc(CTRL_ADDR, 8'hc0);
    chk(pulses - seen, 0);
    global_irq_en <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk(timeout_irq_req, 1'b0);
    global_irq_en <= 1'b1;
    strobe(2);
    rdc(CTRL_ADDR, 8'h40);
    wait_evt(1'b1);
    xfer(1'b1, CTRL_ADDR, 8'hc0);
    rdc(CTRL_ADDR, 8'h40);
    xfer(1'b1, CTRL_ADDR, 8'h48);
    wait_evt(1'b0);
    rdc(CTRL_ADDR, 8'h88);
    chk(timeout_irq_req, 1'b0);
    xfer(1'b0, 12'h000, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    por(1'b1);
    rdc(STAT_ADDR, 8'h01);
    rdc(CTRL_ADDR, 8'h08);
    xfer(1'b1, CTRL_ADDR, 8'h00);
    rdc(CTRL_ADDR, 8'h08);
    xfer(1'b1, CTRL_ADDR, 8'h18);
    xfer(1'b1, CTRL_ADDR, 8'h03);
    rdc(CTRL_ADDR, 8'h0b);
    chk(wdog_running, 1'b1);
    print_verdict();
  end
endmodule : tb
